// File: sim/derw_cpu.sv
// Purpose: CPU bus model facing the row writer.
// Assumes: Requests change at the falling edge.
// Notes: A released address is inverted so a stale value never helps.
`timescale 1ns/10ps
`default_nettype none
module derw_cpu
  import derw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rvalid,
  input  wire logic [7:0] rdata,
  output var derw_bus_t   bus,
  output var logic        wm_set,
  output var logic        wm_clr,
  output var logic        burn
);
  initial begin
    bus = '0;
    wm_set = 1'b0;
    wm_clr = 1'b0;
    burn = 1'b0;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
    bus.addr = ~a;
    bus.wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge clk);
    bus.rd = 1'b0;
    bus.addr = ~a;
    // The answer must stand exactly one cycle after the request.
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask : rd
  // Mode is set with the trigger left low, as software must.
  task automatic pulse(input int k);
    @(negedge clk);
    wm_set = (k == 0);
    wm_clr = (k == 1);
    burn = (k == 2);
    @(negedge clk);
    {wm_set, wm_clr, burn} = 3'b000;
  endtask : pulse
endmodule : derw_cpu
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the row writer.
// Assumes: Burn shortened to two cycles.
// Notes: Stale latch bytes are sought at unwritten addresses of a burned row.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import derw_pkg::*;
  logic       clk;
  logic       rstn;
  logic       rvalid;
  logic       wmf;
  logic       btf;
  logic       ws;
  logic       wc;
  logic       bs;
  logic [7:0] rdata;
  derw_bus_t  bus;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  localparam int TB_BURN = 2;
  derw_top #(.BURN_LEN(TB_BURN)) i_derw_top (.clk(clk), .rstn(rstn), .bus(bus),
    .write_mode_set(ws), .write_mode_clr(wc), .burn_set(bs), .rdata(rdata),
    .rvalid(rvalid), .write_mode_flag(wmf), .burn_trigger_flag(btf));
  derw_cpu i_derw_cpu (.clk(clk), .rvalid(rvalid), .rdata(rdata), .bus(bus),
    .wm_set(ws), .wm_clr(wc), .burn(bs));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_derw_cpu.rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic burn_wait();
    int n;
    n = 0;
    i_derw_cpu.pulse(2);
    @(negedge clk);
    chk({7'h0, btf}, 8'h01);
    for (int i = 0; i < 20 && btf === 1'b1; i++) begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), 8'(TB_BURN + 1));
    chk({6'h0, wmf, btf}, 8'h00);
  endtask : burn_wait
  task automatic t_plain();
    rchk(7'h00, ERASED);
    i_derw_cpu.wr(7'h10, 8'h00);
    rchk(7'h10, ERASED);
    $display("t_plain done");
  endtask : t_plain
  task automatic t_row();
    i_derw_cpu.pulse(0);
    i_derw_cpu.wr(7'h23, 8'h5a);
    i_derw_cpu.wr(7'h23, 8'h0f);
    i_derw_cpu.wr(7'h3f, 8'h11);
    rchk(7'h23, ERASED);
    burn_wait();
    rchk(7'h23, 8'h0a);
    rchk(7'h3f, 8'h11);
    rchk(7'h03, ERASED);
    $display("t_row done");
  endtask : t_row
  task automatic t_clear();
    i_derw_cpu.pulse(0);
    i_derw_cpu.wr(7'h40, 8'h00);
    i_derw_cpu.pulse(1);
    i_derw_cpu.pulse(0);
    i_derw_cpu.wr(7'h61, 8'h33);
    burn_wait();
    rchk(7'h60, ERASED);
    rchk(7'h63, ERASED);
    rchk(7'h40, ERASED);
    rchk(7'h61, 8'h33);
    $display("t_clear done");
  endtask : t_clear
  task automatic t_refuse();
    i_derw_cpu.pulse(2);
    @(negedge clk);
    chk({6'h0, wmf, btf}, 8'h00);
    i_derw_cpu.pulse(0);
    i_derw_cpu.wr(7'h25, 8'h44);
    i_derw_cpu.pulse(2);
    i_derw_cpu.wr(7'h06, 8'h00);
    for (int i = 0; i < 20 && btf !== 1'b0; i++) @(negedge clk);
    chk({6'h0, wmf, btf}, 8'h00);
    rchk(7'h25, 8'h44);
    rchk(7'h06, ERASED);
    rchk(7'h05, ERASED);
    $display("t_refuse done");
  endtask : t_refuse
  initial begin
    rstn = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_plain();
    t_row();
    t_clear();
    t_refuse();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// File: src/derw_pkg.sv
// Purpose: Shared constants and carrier types for the data EEPROM row writer.
// Assumes: One system clock, asynchronous active-low reset, byte-wide CPU bus.
// Notes: No software-visible registers; the control bits are plain ports.
// Summary of operation
// - With write mode clear, CPU reads return stored EEPROM bytes like ordinary read-only memory.
// - Instruction fetches from the EEPROM region are served so that code can run from it.
// - In write mode each CPU write made while no burn runs stores its byte in one of 32 latches picked by the low address bits.
// - Setting the burn trigger programs every latched byte, up to 32, into the EEPROM cells.
// - The target row comes from the upper address bits of the latest write latched in write mode.
// - At the end of programming the trigger and write-mode bits clear in the same cycle.
// - Latches clear only at the end of programming and on a falling edge of write mode.
// - Repeated writes to one location before programming program the AND of the values.
// - Latched but unprogrammed bytes can never be read back.
package derw_pkg;

  localparam int ADDR_W      = 7;
  localparam int DEPTH       = 128;
  localparam int LAT_W       = 5;
  localparam int NLAT        = 32;
  localparam int ROW_W       = ADDR_W - LAT_W;
  localparam int BURN_CYCLES = 8;
  localparam logic [7:0] ERASED = 8'hff;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } derw_bus_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_BURN  = 3'b010,
    S_DONE  = 3'b100
  } derw_state_t;

endpackage : derw_pkg

// File: src/derw_top.sv
// Purpose: Data EEPROM access controller with a 32-byte row latch bank.
// Assumes: Bus inputs are synchronous; reads answer one cycle after rd.
// Notes: Cell array is modelled as flip-flops; a burn takes BURN_LEN cycles, BURN_CYCLES by default.
`timescale 1ns/10ps
`default_nettype none
module derw_top
  import derw_pkg::*;
#(
  parameter int BURN_LEN = BURN_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire derw_bus_t bus,
  input  wire logic      write_mode_set,
  input  wire logic      write_mode_clr,
  input  wire logic      burn_set,
  output logic [7:0]     rdata,
  output logic           rvalid,
  output logic           write_mode_flag,
  output logic           burn_trigger_flag
);

  logic [7:0]       mem_q   [DEPTH];
  logic [7:0]       lat_q   [NLAT];
  logic [NLAT-1:0]  used_q;
  logic [ROW_W-1:0] row_q;
  logic             write_mode_bit_q;
  logic             burn_trigger_bit_q;
  derw_state_t      state_q;
  logic [15:0]      cnt_q;
  logic             wm_fall;
  logic             done;
  logic             lat_wr;

  assign done    = (state_q == S_DONE);
  // A set in the same cycle as a clear wins, so the mode bit and latches survive.
  assign wm_fall = write_mode_bit_q & write_mode_clr & ~write_mode_set & ~done &
                   (state_q == S_IDLE);
  assign lat_wr  = bus.wr & write_mode_bit_q & (state_q == S_IDLE);

  // The write-mode bit cannot be dropped during a burn, so the row stays intact.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_mode_bit_q   <= 1'b0;
      burn_trigger_bit_q <= 1'b0;
    end else if (done) begin
      write_mode_bit_q   <= 1'b0;
      burn_trigger_bit_q <= 1'b0;
    end else if (state_q == S_IDLE) begin
      if (write_mode_set) begin
        write_mode_bit_q <= 1'b1;
      end else if (write_mode_clr) begin
        write_mode_bit_q <= 1'b0;
      end
      if (burn_set && write_mode_bit_q) begin
        burn_trigger_bit_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (burn_trigger_bit_q) begin
            state_q <= S_BURN;
            cnt_q   <= 16'(BURN_LEN - 1);
          end
        end
        S_BURN: begin
          if (cnt_q == 16'h0000) begin
            state_q <= S_DONE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      used_q <= '0;
      row_q  <= '0;
    end else if (done) begin
      used_q <= '0;
    end else begin
      if (wm_fall) begin
        used_q <= '0;
      end
      // A write on the clearing edge was made in write mode, so it is kept.
      if (lat_wr) begin
        used_q[bus.addr[LAT_W-1:0]] <= 1'b1;
        row_q <= bus.addr[ADDR_W-1:LAT_W];
      end
    end
  end

  // Latch contents are don't-care while unused, so they need no reset.
  always_ff @(posedge clk) begin
    if (lat_wr) begin
      if (used_q[bus.addr[LAT_W-1:0]] && !wm_fall) begin
        lat_q[bus.addr[LAT_W-1:0]] <= lat_q[bus.addr[LAT_W-1:0]] & bus.wdata;
      end else begin
        lat_q[bus.addr[LAT_W-1:0]] <= bus.wdata;
      end
    end
  end

  // Cells are written whole at the end of the burn; a real array would take wear time.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= ERASED;
      end
    end else if (done) begin
      for (int i = 0; i < NLAT; i++) begin
        if (used_q[i]) begin
          mem_q[{row_q, LAT_W'(i)}] <= lat_q[i];
        end
      end
    end
  end

  // Reads and fetches look only at the cell array, never at the latches.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= bus.rd;
      if (bus.rd) begin
        rdata <= mem_q[bus.addr];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_mode_flag   <= 1'b0;
      burn_trigger_flag <= 1'b0;
    end else begin
      write_mode_flag   <= write_mode_bit_q & ~done;
      burn_trigger_flag <= (burn_trigger_bit_q | (state_q != S_IDLE)) & ~done;
    end
  end

  a_done_clears_bits: assert property (@(posedge clk) disable iff (!rstn)
    done |=> (!write_mode_bit_q && !burn_trigger_bit_q))
    else $error("Mode and trigger bits not cleared after burn.");

  a_done_clears_used: assert property (@(posedge clk) disable iff (!rstn)
    done |=> (used_q == '0))
    else $error("Latches not cleared after burn.");

  a_fall_clears_used: assert property (@(posedge clk) disable iff (!rstn)
    (wm_fall && !lat_wr) |=> (used_q == '0))
    else $error("Latches not cleared on write mode fall.");

  a_busy_reads_one: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_BURN) |=> burn_trigger_flag)
    else $error("Trigger not read as one during burn.");

  a_read_answers: assert property (@(posedge clk) disable iff (!rstn)
    bus.rd |=> (rvalid && rdata == $past(mem_q[bus.addr])))
    else $error("Read did not return stored byte.");

  a_write_latches: assert property (@(posedge clk) disable iff (!rstn)
    (lat_wr && !done) |=> used_q[$past(bus.addr[LAT_W-1:0])])
    else $error("Write in write mode did not mark its latch.");

  a_row_follows: assert property (@(posedge clk) disable iff (!rstn)
    lat_wr |=> (row_q == $past(bus.addr[ADDR_W-1:LAT_W])))
    else $error("Row not taken from latest write.");

  a_burn_bounded: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_IDLE && burn_trigger_bit_q) |-> ##[1:300] done)
    else $error("Burn did not complete in time.");

  a_refused_burn: assert property (@(posedge clk) disable iff (!rstn)
    (burn_set && !write_mode_bit_q && !burn_trigger_bit_q && state_q == S_IDLE)
      |=> !burn_trigger_bit_q)
    else $error("Trigger taken without write mode.");

  a_burn_ignores_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && state_q == S_BURN) |=> (used_q == $past(used_q)))
    else $error("Write during burn reached the latches.");

  a_mode_held_burn: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_BURN) |=> $stable(write_mode_bit_q))
    else $error("Write mode changed during burn.");

  a_flag_low_idle: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_IDLE && !burn_trigger_bit_q) |=> !burn_trigger_flag)
    else $error("Trigger read as one while idle.");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
    !bus.rd |=> !rvalid)
    else $error("Read answer without a request.");

  a_cnt_loaded: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_IDLE && burn_trigger_bit_q)
      |=> (state_q == S_BURN && cnt_q == 16'(BURN_LEN - 1)))
    else $error("Burn did not start with a full count.");

  a_done_returns: assert property (@(posedge clk) disable iff (!rstn)
    done |=> (state_q == S_IDLE))
    else $error("Controller did not return to idle after burn.");

  a_mode_sets: assert property (@(posedge clk) disable iff (!rstn)
    (write_mode_set && state_q == S_IDLE) |=> write_mode_bit_q)
    else $error("Write mode not entered.");

  a_fall_keeps_write: assert property (@(posedge clk) disable iff (!rstn)
    (wm_fall && lat_wr) |=> (used_q == (NLAT'(1) << $past(bus.addr[LAT_W-1:0]))))
    else $error("Latch clear did not keep the coinciding write alone.");

  a_trigger_needs_mode: assert property (@(posedge clk) disable iff (!rstn)
    $rose(burn_trigger_bit_q) |-> $past(write_mode_bit_q))
    else $error("Trigger rose outside write mode.");

  a_row_held: assert property (@(posedge clk) disable iff (!rstn)
    !lat_wr |=> $stable(row_q))
    else $error("Row changed without a write in write mode.");

  a_flag_drops_done: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == S_DONE) |=> !burn_trigger_flag)
    else $error("Trigger still read as one after burn.");

endmodule : derw_top
`default_nettype wire
